// file: hdl/rsq_map.svh
// Register offsets, field positions, reset values and cycle counts of the reset sequencer
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

// Word offsets on the register bus
`define RSQ_OFS_CAUSE 2'h0
`define RSQ_OFS_CTRL 2'h1
`define RSQ_OFS_WDOG 2'h2

// Field positions in reset_cause_status
`define RSQ_BIT_POR 0
`define RSQ_BIT_PIN 1
`define RSQ_BIT_WDOG 2
`define RSQ_BIT_BADOP 3
`define RSQ_BIT_BADADR 4
`define RSQ_BIT_MON 5
`define RSQ_BIT_LOWSUP 6
`define RSQ_BIT_LOWPWR 7

// Field positions in the control register
`define RSQ_BIT_STOP_OK 0

// Reset values
`define RSQ_CAUSE_RST 8'h81
`define RSQ_CTRL_RST 1'h0

// Cycle counts of the reference clock
`define RSQ_STAB_CYC 4096
`define RSQ_PIN_CYC 32
`define RSQ_HOLD_CYC 32
`define RSQ_EXT_MIN_CYC 4
`define RSQ_WDOG_CYC 262144
`define RSQ_BUS_DIV 4

// Reset vector and its erased content
`define RSQ_VEC_ADDR 16'hFFFE
`define RSQ_ERASED 8'hFF

`endif

// file: hdl/rsq_pkg.sv
// Types shared by the reset sequencer
package rsq_pkg;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        RSQ_RUN = 6'h01,
        RSQ_EXT = 6'h02,
        RSQ_LOWSUP = 6'h04,
        RSQ_STAB = 6'h08,
        RSQ_PIN = 6'h10,
        RSQ_HOLD = 6'h20
    } rsq_state_t;

    // Register bus word address
    typedef logic [1:0] rsq_addr_t;

endpackage

// file: hdl/rsq_top.sv
// Reset sequencer with reset-cause status register and Avalon-MM slave
`include "rsq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rsq_top #(
    parameter int STAB_CYC = `RSQ_STAB_CYC,
    parameter int WDOG_CYC = `RSQ_WDOG_CYC,
    parameter int WDOG_W = 18
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire rsq_pkg::rsq_addr_t i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rst_pin,
    output logic o_rst_pin_o,
    output logic o_rst_pin_oe,
    input wire logic i_low_supply,
    input wire logic i_irq_pin,
    input wire logic i_bad_opcode,
    input wire logic i_stop_exec,
    input wire logic i_fetch_valid,
    input wire logic i_fetch_mapped,
    input wire logic [7:0] i_vec_hi,
    input wire logic [7:0] i_vec_lo,
    input wire logic i_irq_req,
    input wire logic i_insn_done,
    output logic o_core_rst,
    output logic o_clk_hold,
    output logic o_bus_clk_en,
    output logic o_vec_fetch,
    output logic [15:0] o_vec_addr,
    output logic o_irq_take,
    output rsq_pkg::rsq_state_t o_seq_state
);
    import rsq_pkg::*;
    localparam logic [12:0] STAB_LAST = 13'(STAB_CYC - 1);
    localparam logic [12:0] PIN_LAST = 13'(`RSQ_PIN_CYC - 1);
    localparam logic [12:0] HOLD_LAST = 13'(`RSQ_HOLD_CYC - 1);
    localparam logic [2:0] EXT_MIN = 3'(`RSQ_EXT_MIN_CYC);
    localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYC - 1);
    localparam logic [1:0] DIV_LAST = 2'(`RSQ_BUS_DIV - 1);
    ////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_r; // First release stage
    logic rst_n; // Released reset copy
    logic [2:0] in_meta_r; // First stage: pin, low supply, irq
    logic [2:0] in_sync_r; // Second stage
    logic pin_s; // Reset pin level
    logic low_s; // Supply detector reports low
    logic irq_s; // Interrupt pin level
    // Two-stage reset release
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end
    // Pin synchronisers
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_r <= 3'h5;
            in_sync_r <= 3'h5;
        end else if (i_ce) begin
            in_meta_r <= {i_irq_pin, i_low_supply, i_rst_pin};
            in_sync_r <= in_meta_r;
        end
    end
    assign pin_s = in_sync_r[0];
    assign low_s = in_sync_r[1];
    assign irq_s = in_sync_r[2];
    ////////////////////////////////////////////////////////////////////////
    // Register bus slave
    ////////////////////////////////////////////////////////////////////////
    logic ack_r; // Second cycle of an access
    logic req; // Read or write pending
    logic acc; // Access accepted at this edge
    logic rd_cause; // Cause register read accepted
    logic wr_wdog; // Watchdog service write accepted
    logic stop_ok_r; // Stop instruction permitted
    logic [7:0] cause_r; // reset_cause_status
    logic [WDOG_W-1:0] wdog_r; // Watchdog counter
    logic [31:0] rdata_nxt; // Read data mux
    assign req = i_avs_read | i_avs_write;
    // Answer in the second cycle; frozen while the clock enable is low
    assign o_avs_waitrequest = req & ~(ack_r & i_ce);
    assign acc = req & ack_r & i_ce;
    assign rd_cause = acc & i_avs_read & (i_avs_address == `RSQ_OFS_CAUSE);
    assign wr_wdog = acc & i_avs_write & (i_avs_address == `RSQ_OFS_WDOG);
    // Read mux, unmapped reads as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (i_avs_address)
            `RSQ_OFS_CAUSE: rdata_nxt = {24'h00_0000, cause_r};
            `RSQ_OFS_CTRL: rdata_nxt = {31'h0000_0000, stop_ok_r};
            `RSQ_OFS_WDOG: rdata_nxt = 32'(wdog_r);
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end
    // Handshake and read data capture in the first cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_ce) begin
            ack_r <= req & ~ack_r;
            if (req && !ack_r) begin
                o_avs_readdata <= rdata_nxt;
            end
        end
    end
    // Control register write
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_ok_r <= `RSQ_CTRL_RST;
        end else if (acc && i_avs_write && i_avs_address == `RSQ_OFS_CTRL) begin
            stop_ok_r <= i_avs_writedata[`RSQ_BIT_STOP_OK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sources
    ////////////////////////////////////////////////////////////////////////
    rsq_state_t state_r; // Sequencer state
    rsq_state_t state_nxt;
    logic [12:0] cnt_r; // Cycle counter of the current phase
    logic [12:0] cnt_nxt;
    logic [2:0] ext_r; // Low-pin run length
    logic running; // Core out of reset
    logic wdog_ovf; // Watchdog overflow
    logic bad_op; // Undefined or forbidden opcode
    logic bad_fetch; // Opcode fetch from unmapped space
    logic int_trig; // Any internal reset cause
    logic ext_trig; // External reset recognised
    logic hold_end; // Last cycle of the core hold
    logic por_seq_r; // Sequence began with power-on
    assign running = (state_r == RSQ_RUN);
    assign wdog_ovf = (wdog_r == WDOG_LAST);
    assign bad_op = i_bad_opcode | (i_stop_exec & ~stop_ok_r);
    // Only opcode fetches count, data accesses are not looked at
    assign bad_fetch = i_fetch_valid & ~i_fetch_mapped;
    assign int_trig = running & (wdog_ovf | bad_op | bad_fetch);
    assign ext_trig = running & ~pin_s & (ext_r == EXT_MIN - 3'h1);
    assign hold_end = (state_r == RSQ_HOLD) & (cnt_r == HOLD_LAST);
    // Watchdog counter, cleared by any service write
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_r <= '0;
        end else if (i_ce) begin
            if (!running || wr_wdog) begin
                wdog_r <= '0;
            end else begin
                wdog_r <= wdog_r + WDOG_W'(1);
            end
        end
    end
    // Low-pin run length while running
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_r <= 3'h0;
        end else if (i_ce) begin
            if (running && !pin_s && ext_r != EXT_MIN) begin
                ext_r <= ext_r + 3'h1;
            end else if (pin_s || !running) begin
                ext_r <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    ////////////////////////////////////////////////////////////////////////
    // Next state; low supply overrides every phase
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 13'h1;
        if (low_s && state_r != RSQ_LOWSUP) begin
            state_nxt = RSQ_LOWSUP;
            cnt_nxt = 13'h0;
        end else begin
            case (state_r)
                RSQ_RUN: begin
                    cnt_nxt = 13'h0;
                    if (int_trig) begin
                        state_nxt = RSQ_PIN;
                    end else if (ext_trig) begin
                        state_nxt = RSQ_EXT;
                    end
                end
                RSQ_EXT: begin
                    cnt_nxt = 13'h0;
                    if (pin_s) begin
                        state_nxt = RSQ_HOLD;
                    end
                end
                RSQ_LOWSUP: begin
                    cnt_nxt = 13'h0;
                    if (!low_s) begin
                        state_nxt = RSQ_STAB;
                    end
                end
                RSQ_STAB: begin
                    if (cnt_r == STAB_LAST) begin
                        state_nxt = RSQ_PIN;
                        cnt_nxt = 13'h0;
                    end
                end
                RSQ_PIN: begin
                    if (cnt_r == PIN_LAST) begin
                        state_nxt = RSQ_HOLD;
                        cnt_nxt = 13'h0;
                    end
                end
                RSQ_HOLD: begin
                    if (hold_end) begin
                        state_nxt = RSQ_RUN;
                        cnt_nxt = 13'h0;
                    end
                end
                default: begin
                    state_nxt = RSQ_STAB;
                    cnt_nxt = 13'h0;
                end
            endcase
        end
    end
    // State and counter; power-on starts in stabilisation
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= RSQ_STAB;
            cnt_r <= 13'h0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    // Power-on marker for monitor entry
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_seq_r <= 1'b1;
        end else if (i_ce && hold_end) begin
            por_seq_r <= 1'b0;
        end
    end
    // Pin driven low and clocks held from state decode
    assign o_rst_pin_o = 1'b0;
    assign o_rst_pin_oe = (state_r == RSQ_STAB) | (state_r == RSQ_LOWSUP)
        | (state_r == RSQ_PIN);
    assign o_clk_hold = (state_r == RSQ_STAB) | (state_r == RSQ_LOWSUP);
    assign o_core_rst = ~running;
    assign o_seq_state = state_r;
    // Vector fetch strobe at release of the core
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_vec_fetch <= 1'b0;
            o_vec_addr <= `RSQ_VEC_ADDR;
        end else if (i_ce) begin
            o_vec_fetch <= hold_end;
            o_vec_addr <= `RSQ_VEC_ADDR;
        end
    end
    // Bus clock enable at reference over four, phase reset with the core
    logic [1:0] div_r; // Bus clock divider
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 2'h0;
            o_bus_clk_en <= 1'b0;
        end else if (i_ce) begin
            div_r <= o_core_rst ? 2'h0 : div_r + 2'h1;
            o_bus_clk_en <= ~o_core_rst & (div_r == DIV_LAST);
        end
    end
    // Interrupt taken only at an instruction boundary, never over an internal reset cause
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq_take <= 1'b0;
        end else if (i_ce) begin
            o_irq_take <= running & ~int_trig & i_irq_req & i_insn_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause register
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] flag_set; // Flags raised this cycle
    logic [7:0] flag_clr; // Flags reported by the accepted read
    // Set terms per cause
    always_comb begin
        flag_set = 8'h00;
        flag_set[`RSQ_BIT_WDOG] = running & wdog_ovf;
        flag_set[`RSQ_BIT_BADOP] = running & bad_op;
        flag_set[`RSQ_BIT_BADADR] = running & bad_fetch;
        flag_set[`RSQ_BIT_LOWSUP] = low_s & (state_r != RSQ_LOWSUP);
        flag_set[`RSQ_BIT_PIN] = ext_trig | (hold_end & ~pin_s);
        flag_set[`RSQ_BIT_MON] = hold_end & por_seq_r & irq_s & (i_vec_hi == `RSQ_ERASED)
            & (i_vec_lo == `RSQ_ERASED);
    end
    // Only bits shown to the reader are cleared, so a late set survives
    assign flag_clr = rd_cause ? o_avs_readdata[7:0] : 8'h00;
    // Sticky flags; set wins over clear
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= `RSQ_CAUSE_RST;
        end else if (i_ce) begin
            cause_r <= (cause_r & ~flag_clr) | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////
    property p_abort;
        @(posedge i_clk) disable iff (!rst_n)
        (int_trig && !low_s && i_ce) |=> (o_core_rst && state_r == RSQ_PIN);
    endproperty
    a_abort: assert property (p_abort) else $error("reset cause did not abort core");
    property p_div;
        @(posedge i_clk) disable iff (!rst_n)
        (o_core_rst && i_ce) |=> (div_r == 2'h0 && !o_bus_clk_en);
    endproperty
    a_div: assert property (p_div) else $error("bus divider not reset");
    property p_pin_len;
        @(posedge i_clk) disable iff (!rst_n)
        (state_r == RSQ_PIN && cnt_r == PIN_LAST && i_ce && !low_s) |=>
            (state_r == RSQ_HOLD && !o_rst_pin_oe && cnt_r == 13'h0);
    endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin phase length wrong");
    property p_hold;
        @(posedge i_clk) disable iff (!rst_n)
        (hold_end && i_ce && !low_s) |=> (o_vec_fetch && !o_core_rst);
    endproperty
    a_hold: assert property (p_hold) else $error("core hold end wrong");
    property p_stab;
        @(posedge i_clk) disable iff (!rst_n)
        (state_r == RSQ_STAB) |-> (o_rst_pin_oe && o_clk_hold && cnt_r <= STAB_LAST);
    endproperty
    a_stab: assert property (p_stab) else $error("stabilisation phase wrong");
    property p_low;
        @(posedge i_clk) disable iff (!rst_n)
        (low_s && i_ce) |=> (o_rst_pin_oe
            && (cause_r[`RSQ_BIT_LOWSUP] || $past(state_r == RSQ_LOWSUP)));
    endproperty
    a_low: assert property (p_low) else $error("low supply not held");
    property p_wdog;
        @(posedge i_clk) disable iff (!rst_n)
        wr_wdog |=> (wdog_r == '0);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
    property p_read_clr;
        @(posedge i_clk) disable iff (!rst_n)
        rd_cause |=> ((cause_r & $past(o_avs_readdata[7:0] & ~flag_set)) == 8'h00);
    endproperty
    a_read_clr: assert property (p_read_clr) else $error("read did not clear");
    property p_sticky;
        @(posedge i_clk) disable iff (!rst_n)
        !rd_cause |=> ((cause_r & $past(cause_r)) == $past(cause_r));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without read");
    property p_irq;
        @(posedge i_clk) disable iff (!rst_n)
        o_irq_take |-> ($past(i_insn_done) && $past(running));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt inside instruction");

endmodule
`default_nettype wire

// file: verification/rsq_board.sv
// Board-side reset circuitry sharing the open-drain reset pin
`timescale 1ns/1ps
`default_nettype none

module rsq_board (
    input wire logic i_clk,
    input wire logic i_dut_o,
    input wire logic i_dut_oe,
    input wire logic i_push,
    input wire logic [7:0] i_stretch,
    output logic o_pin
);
    logic oe_r = 1'b0; // Device enable one cycle back
    logic [7:0] str_r = 8'h00; // Cycles left to keep the pin low

    ////////////////////////////////////////////////////////////////////////////////
    // Supervisor-style stretch of the device's pulse, slow release
    always_ff @(posedge i_clk) begin
        oe_r <= i_dut_oe;
        if (oe_r && !i_dut_oe) begin
            str_r <= i_stretch;
        end else if (str_r != 8'h00) begin
            str_r <= str_r - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wired level with pull-up; a push is held by the bench for its length
    assign o_pin = (i_dut_oe ? i_dut_o : 1'b1) & !i_push & (str_r == 8'h00);
endmodule
`default_nettype wire

// file: verification/test_reset_sequencer_status.sv
// Self-checking bench for the reset sequencer and its cause register
`include "rsq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module test_reset_sequencer_status;
    import rsq_pkg::*;
    localparam int STAB = 16; // Shortened stabilisation
    localparam int WDOG = 2000; // Shortened watchdog period
    localparam logic [31:0] F_POR = 32'h1 << `RSQ_BIT_POR; // Cause flags
    localparam logic [31:0] F_PIN = 32'h1 << `RSQ_BIT_PIN;
    localparam logic [31:0] F_WDG = 32'h1 << `RSQ_BIT_WDOG;
    localparam logic [31:0] F_OP = 32'h1 << `RSQ_BIT_BADOP;
    localparam logic [31:0] F_ADR = 32'h1 << `RSQ_BIT_BADADR;
    localparam logic [31:0] F_MON = 32'h1 << `RSQ_BIT_MON;
    localparam logic [31:0] F_LS = 32'h1 << `RSQ_BIT_LOWSUP;
    localparam logic [31:0] F_LP = 32'h1 << `RSQ_BIT_LOWPWR;
    logic i_clk = 1'b0; // Reference clock
    logic i_rst_b = 1'b0; // Power-on reset
    logic ce = 1'b1;
    rsq_addr_t av_addr = 2'h0; // Bus master signals
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic [31:0] rdata;
    logic pin; // Wired pin level
    logic pin_o;
    logic pin_oe;
    logic push = 1'b0; // Board pushes the pin low
    logic [7:0] stretch = 8'h00;
    logic low_sup = 1'b0; // Core and supply stimulus
    logic irq_pin = 1'b1;
    logic bad_op = 1'b0;
    logic stop_ex = 1'b0;
    logic f_valid = 1'b0;
    logic f_mapped = 1'b1;
    logic irq_req = 1'b0;
    logic insn_done = 1'b0;
    logic [7:0] vec_hi = 8'hFF; // Erased vector at power-on
    logic [7:0] vec_lo = 8'hFF;
    logic core_rst;
    logic clk_hold;
    logic bclk;
    logic vfetch;
    logic irq_take;
    logic [15:0] vec_addr;
    rsq_state_t state;
    int failures = 0;
    int checks_done = 0;
    int stab_n = 0; // Phase counters of the monitor
    int pin_n = 0;
    int hold_n = 0;
    int bclk_n = 0;
    int take_n = 0;
    logic mon_clr = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        forever #20 i_clk = ~i_clk;
    end

    rsq_top #(.STAB_CYC(STAB), .WDOG_CYC(WDOG), .WDOG_W(18)) dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
        .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
        .i_rst_pin(pin), .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe),
        .i_low_supply(low_sup), .i_irq_pin(irq_pin), .i_bad_opcode(bad_op),
        .i_stop_exec(stop_ex), .i_fetch_valid(f_valid), .i_fetch_mapped(f_mapped),
        .i_vec_hi(vec_hi), .i_vec_lo(vec_lo), .i_irq_req(irq_req), .i_insn_done(insn_done),
        .o_core_rst(core_rst), .o_clk_hold(clk_hold), .o_bus_clk_en(bclk),
        .o_vec_fetch(vfetch), .o_vec_addr(vec_addr), .o_irq_take(irq_take), .o_seq_state(state)
    );

    rsq_board board (
        .i_clk(i_clk), .i_dut_o(pin_o), .i_dut_oe(pin_oe),
        .i_push(push), .i_stretch(stretch), .o_pin(pin)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor counting reset phases and pulses
    always @(posedge i_clk) begin
        if (mon_clr) begin
            stab_n <= 0;
            pin_n <= 0;
            hold_n <= 0;
            bclk_n <= 0;
            take_n <= 0;
        end else begin
            stab_n <= stab_n + int'(state === RSQ_STAB);
            pin_n <= pin_n + int'(pin_oe === 1'b1 && clk_hold === 1'b0);
            hold_n <= hold_n + int'(core_rst === 1'b1 && pin_oe === 1'b0 && pin === 1'b1);
            bclk_n <= bclk_n + int'(bclk === 1'b1);
            take_n <= take_n + int'(irq_take === 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task wrap_up;
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t ns: seen %h wanted %h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task clr; // Zero the monitor over one edge
        mon_clr <= 1'b1;
        cyc(1);
        mon_clr <= 1'b0;
    endtask

    // One Avalon access, held until waitrequest is seen low
    task bus(input logic wr, input rsq_addr_t a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        av_addr <= a;
        av_wdata <= wd;
        av_rd <= !wr;
        av_wr <= wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        if (av_wait !== 1'b0) failures++;
        rdata = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    task rd_chk(input rsq_addr_t a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    // Core event pulse: 0 bad opcode, 1 stop, 2 unmapped fetch, 3 mapped fetch
    task strobe(input int k);
        bad_op <= (k == 0);
        stop_ex <= (k == 1);
        f_valid <= (k >= 2);
        f_mapped <= (k == 3);
        cyc(1);
        bad_op <= 1'b0;
        stop_ex <= 1'b0;
        f_valid <= 1'b0;
    endtask

    // Wait for the vector fetch, then for the core to stay running
    task boot;
        int n;
        n = 0;
        while (vfetch !== 1'b1 && n < 8000) begin
            @(posedge i_clk);
            n++;
        end
        chk({vfetch, vec_addr}, {1'b1, `RSQ_VEC_ADDR});
        n = 0;
        for (int k = 0; k < 3000 && n < 40; k++) begin
            @(posedge i_clk);
            n = (core_rst === 1'b0) ? n + 1 : 0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        cyc(30000);
        failures++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        cyc(10);
        i_rst_b <= 1'b1;
        clr();
        cyc(5);
        chk({pin_oe, clk_hold, core_rst, bclk}, 4'hE);
        boot();
        chk(pin_n, 32);
        chk(hold_n, 32);
        vec_hi <= 8'h12;
        vec_lo <= 8'h34;
        rd_chk(`RSQ_OFS_CAUSE, F_POR | F_LP | F_MON);
        rd_chk(`RSQ_OFS_CAUSE, 32'h0);
        clr();
        strobe(0);
        boot();
        chk(pin_n, 32);
        chk(hold_n, 32);
        strobe(2);
        boot();
        bus(1'b1, `RSQ_OFS_CAUSE, 32'hFF);
        rd_chk(`RSQ_OFS_CAUSE, F_OP | F_ADR);
        bus(1'b1, 2'h3, 32'h5A);
        rd_chk(2'h3, 32'h0);
        strobe(3);
        cyc(10);
        chk(core_rst, 1'b0);
        rd_chk(`RSQ_OFS_CTRL, 32'h0);
        strobe(1);
        boot();
        rd_chk(`RSQ_OFS_CAUSE, F_OP);
        bus(1'b1, `RSQ_OFS_CTRL, 32'h1);
        rd_chk(`RSQ_OFS_CTRL, 32'h1);
        strobe(1);
        cyc(10);
        chk(core_rst, 1'b0);
        bus(1'b1, `RSQ_OFS_CTRL, 32'h0);
        clr();
        cyc(41);
        chk(bclk_n, 40 / `RSQ_BUS_DIV);
        irq_req <= 1'b1;
        clr();
        cyc(11);
        chk(take_n, 0);
        insn_done <= 1'b1;
        cyc(1);
        insn_done <= 1'b0;
        cyc(4);
        chk(take_n, 1);
        irq_req <= 1'b0;
        push <= 1'b1;
        cyc(2);
        push <= 1'b0;
        cyc(10);
        chk(core_rst, 1'b0);
        push <= 1'b1;
        cyc(8);
        push <= 1'b0;
        boot();
        rd_chk(`RSQ_OFS_CAUSE, F_PIN);
        stretch <= 8'd40;
        strobe(0);
        boot();
        stretch <= 8'h00;
        rd_chk(`RSQ_OFS_CAUSE, F_OP | F_PIN);
        low_sup <= 1'b1;
        cyc(20);
        chk({pin_oe, clk_hold, core_rst}, 3'h7);
        low_sup <= 1'b0;
        clr();
        boot();
        chk(stab_n, STAB);
        chk(pin_n, 32);
        chk(hold_n, 32);
        rd_chk(`RSQ_OFS_CAUSE, F_LS);
        cyc(WDOG - 200);
        bus(1'b1, `RSQ_OFS_WDOG, 32'h0);
        cyc(WDOG - 200);
        bus(1'b1, `RSQ_OFS_WDOG, 32'h0);
        cyc(WDOG - 50);
        chk(core_rst, 1'b0);
        boot();
        rd_chk(`RSQ_OFS_CAUSE, F_WDG);
        wrap_up();
    end
endmodule
`default_nettype wire
